// *** fo_pkg.sv ***
// Purpose: Shared constants and types for the audio source failover controller.
// Assumes: Levels and thresholds are signed tenths of a dBFS; delays are tenths of a second.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
`default_nettype none
package fo_pkg;
  // Number formats.
  localparam int LVL_W = 13;
  localparam int DLY_W = 12;
  // Clock and delay resolution.
  localparam longint CLK_PERIOD_NS = 50;
  localparam longint TICK_NS = 100_000_000;
  localparam int TICK_CYC = int'((TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Legal ranges and reset values, delays in 0.1 s, thresholds in 0.1 dBFS.
  localparam logic signed [LVL_W-1:0] DLY_MIN = 13'sh0001;
  localparam logic signed [LVL_W-1:0] DLY_MAX = 13'sh0BB8;
  localparam logic signed [LVL_W-1:0] DLY_RST = 13'sh0BB8;
  localparam logic signed [LVL_W-1:0] THR_MIN = -13'sh0258;
  localparam logic signed [LVL_W-1:0] THR_MAX = -13'sh0001;
  localparam logic signed [LVL_W-1:0] THR_RST = -13'sh0258;
  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PEND = 8'h08;
  localparam logic [7:0] OFS_CMT = 8'h18;
  localparam logic [7:0] OFS_ACT = 8'h20;
  // Parameter slots, same order for pending and active copies.
  localparam int P_CDLY = 0;
  localparam int P_RDLY = 1;
  localparam int P_CTHR = 2;
  localparam int P_RTHR = 3;
  // Field positions.
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_MAN_BIT = 1;
  localparam int CMT_OK_BIT = 0;
  localparam int CMT_CAN_BIT = 1;
  localparam int ST_BKP_BIT = 0;
  localparam int ST_CRUN_BIT = 1;
  localparam int ST_RRUN_BIT = 2;
  localparam int ST_REJ_BIT = 3;
  // Control reset: automatic mode, manual choice on main.
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic CTRL_MAN_RST = 1'b0;
  // Active source, one-hot.
  typedef enum logic [1:0] {
    FO_MAIN = 2'b01,
    FO_BKUP = 2'b10
  } fo_src_t;
endpackage : fo_pkg
`default_nettype wire

// *** fo_dly_tmr.sv ***
// Purpose: Delay timer counting 0.1 s ticks while its condition holds.
// Assumes: dly is at least one tick.
// Notes: Dropping run clears the prescaler too, so each restart begins at zero.
`timescale 1ns/1ns
`default_nettype none
module fo_dly_tmr import fo_pkg::*; #(
  parameter int TICKS = TICK_CYC,
  parameter int CW = DLY_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic run,
  input wire logic [CW-1:0] dly,
  output logic done
);
  localparam int PW = $clog2(TICKS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICKS - 1);

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [CW-1:0] cnt;
  } fo_tmr_t;

  fo_tmr_t st_r;
  fo_tmr_t st_nxt;

  // Count ticks while the condition holds; any break restarts from zero.
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt = '0; // see [R13]
    end else if (st_r.presc == PRE_LAST) begin
      st_nxt.presc = '0;
      if (st_r.cnt != '1) begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end else begin
      st_nxt.presc = st_r.presc + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Done only after the full delay has been counted without a break.
  assign done = run && (st_r.cnt >= dly); // see [R03]

  restart_zero_a: assert property (@(posedge mclk) disable iff (srst) // see [R13]
    !run |=> (st_r.cnt == '0) && (st_r.presc == '0))
    else $error("timer did not restart from zero");
  done_full_a: assert property (@(posedge mclk) disable iff (srst) // see [R03]
    done |-> $past(run) && (st_r.cnt >= dly))
    else $error("timer done before delay elapsed");
endmodule : fo_dly_tmr
`default_nettype wire

// *** fo_param.sv ***
// Purpose: One committed setting, loaded from its pending copy on confirm.
// Assumes: lo is not above hi.
// Notes: A value outside lo..hi is refused and the stored value is kept.
`timescale 1ns/1ns
`default_nettype none
module fo_param import fo_pkg::*; #(
  parameter logic signed [LVL_W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic commit,
  input wire logic signed [LVL_W-1:0] pend,
  input wire logic signed [LVL_W-1:0] lo,
  input wire logic signed [LVL_W-1:0] hi,
  output logic signed [LVL_W-1:0] val,
  output logic ok
);
  typedef struct packed {
    logic signed [LVL_W-1:0] val;
  } fo_prm_t;

  fo_prm_t st_r;
  fo_prm_t st_nxt;

  // Range check is live so the owner can report a refused edit.
  assign ok = (pend >= lo) && (pend <= hi);

  // Stored value changes only on a confirmed, in-range edit.
  always_comb begin
    st_nxt = st_r;
    if (commit && ok) begin
      st_nxt.val = pend; // see [R12]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign val = st_r.val;

  hold_no_cmt_a: assert property (@(posedge mclk) disable iff (srst) // see [R12]
    !commit |=> $stable(val))
    else $error("setting changed without confirm");
  in_range_a: assert property (@(posedge mclk) disable iff (srst) // see [R09]
    (commit && !ok) |=> (val == $past(val)))
    else $error("refused value was stored");
endmodule : fo_param
`default_nettype wire

// *** fo_failover.sv ***
// Purpose: Automatic main/backup audio source failover with APB setup registers.
// Assumes: MAIN_LEVEL is the measured main peak in signed 0.1 dBFS, synchronous to MCLK.
// Notes: APB answers with no wait states; settings apply only when confirmed.
// Functional notes
// [R01] The main input counts as failed only while its level is below the changeover threshold.
// [R02] The switch to backup waits the changeover delay after the level drops below threshold.
// [R03] Only a dip lasting through the whole changeover delay causes a transfer.
// [R04] On backup, main returns once its level stays above the return threshold for the delay.
// [R05] Both delays are settable from 0.1 s to 300 s in steps of 0.1 s.
// [R06] Both delays reset to 300 s.
// [R07] Both thresholds are settable from -60.0 to -0.1 dBFS in steps of 0.1 dBFS.
// [R08] Both thresholds reset to -60.0 dBFS.
// [R09] A return threshold below the changeover threshold is refused.
// [R10] Thresholds and delays steer selection only in automatic mode.
// [R11] Manual mode keeps the operator's choice and never switches on its own.
// [R12] An edit applies only on confirm, and cancel restores the stored value.
// [R13] A level crossing back before the delay ends cancels the timer, which restarts at zero.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module fo_failover import fo_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [LVL_W-1:0] MAIN_LEVEL,
  output logic SRC_BACKUP
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic auto_mode;
    logic man_bkp;
    fo_src_t src;
    logic rej;
    logic [3:0][LVL_W-1:0] pend;
  } fo_top_t;

  fo_top_t st_r;
  fo_top_t st_nxt;

  logic [3:0][LVL_W-1:0] act;
  logic [3:0] ok;
  logic signed [LVL_W-1:0] lo [4];
  logic signed [LVL_W-1:0] hi [4];
  logic setup;
  logic acc;
  logic wr;
  logic commit;
  logic cancel;
  logic chg_run;
  logic ret_run;
  logic chg_done;
  logic ret_done;
  logic signed [LVL_W-1:0] new_cthr;

  // APB phases; a write lands only in the access cycle, which is always ready.
  assign setup = PSEL && !PENABLE;
  assign acc = PSEL && PENABLE && st_r.pready;
  assign wr = acc && PWRITE;
  assign commit = wr && (PADDR == OFS_CMT) && PWDATA[CMT_OK_BIT]; // see [R12]
  assign cancel = wr && (PADDR == OFS_CMT) && PWDATA[CMT_CAN_BIT] && !PWDATA[CMT_OK_BIT];

  // The return floor follows the changeover threshold that this commit leaves in force.
  assign new_cthr = ok[P_CTHR] ? $signed(st_r.pend[P_CTHR]) : $signed(act[P_CTHR]);

  // Limits per slot; the return floor is what makes a low return threshold bounce.
  always_comb begin
    lo[P_CDLY] = DLY_MIN; // see [R05]
    hi[P_CDLY] = DLY_MAX;
    lo[P_RDLY] = DLY_MIN;
    hi[P_RDLY] = DLY_MAX;
    lo[P_CTHR] = THR_MIN; // see [R07]
    hi[P_CTHR] = THR_MAX;
    lo[P_RTHR] = (new_cthr > THR_MIN) ? new_cthr : THR_MIN; // see [R09]
    hi[P_RTHR] = THR_MAX;
  end

  // One stored setting per slot, each with its own reset value.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_prm
      localparam logic signed [LVL_W-1:0] RV = (gi < 2) ? DLY_RST : THR_RST;
      fo_param #(
        .RST_VAL(RV) // see [R06] see [R08]
      ) u_prm (
        .mclk(MCLK),
        .srst(SRST),
        .commit(commit),
        .pend(st_r.pend[gi]),
        .lo(lo[gi]),
        .hi(hi[gi]),
        .val(act[gi]),
        .ok(ok[gi])
      );
    end
  endgenerate

  // Timers run only in automatic mode and only while their crossing lasts.
  assign chg_run = st_r.auto_mode && (st_r.src == FO_MAIN) &&
                   ($signed(MAIN_LEVEL) < $signed(act[P_CTHR])); // see [R01] see [R10]
  assign ret_run = st_r.auto_mode && (st_r.src == FO_BKUP) &&
                   ($signed(MAIN_LEVEL) > $signed(act[P_RTHR])); // see [R04] see [R10]

  fo_dly_tmr #(
    .TICKS(TICK_CYCLES),
    .CW(DLY_W)
  ) u_chg_tmr (
    .mclk(MCLK),
    .srst(SRST),
    .run(chg_run),
    .dly(act[P_CDLY][DLY_W-1:0]),
    .done(chg_done)
  );

  fo_dly_tmr #(
    .TICKS(TICK_CYCLES),
    .CW(DLY_W)
  ) u_ret_tmr (
    .mclk(MCLK),
    .srst(SRST),
    .run(ret_run),
    .dly(act[P_RDLY][DLY_W-1:0]),
    .done(ret_done)
  );

  // Bus decode, settings edits and the source state machine.
  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = '0;
    hit = 1'b1;
    st_nxt = st_r;
    unique case (PADDR)
      OFS_CTRL: begin
        rd[CTRL_AUTO_BIT] = st_r.auto_mode;
        rd[CTRL_MAN_BIT] = st_r.man_bkp;
      end
      OFS_STAT: begin
        rd[ST_BKP_BIT] = (st_r.src == FO_BKUP);
        rd[ST_CRUN_BIT] = chg_run;
        rd[ST_RRUN_BIT] = ret_run;
        rd[ST_REJ_BIT] = st_r.rej;
        hit = !PWRITE;
      end
      OFS_PEND, OFS_PEND + 8'h04, OFS_PEND + 8'h08, OFS_PEND + 8'h0C: begin
        rd = 32'(signed'(st_r.pend[PADDR[3:2] - 2'h2]));
      end
      OFS_CMT: begin
        rd = '0;
      end
      OFS_ACT, OFS_ACT + 8'h04, OFS_ACT + 8'h08, OFS_ACT + 8'h0C: begin
        rd = 32'(signed'(act[PADDR[3:2]]));
        hit = !PWRITE;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // Answer is prepared in setup so the access cycle is ready at once.
    st_nxt.pready = setup;
    st_nxt.pslverr = setup && !hit;
    if (setup && !PWRITE) begin
      st_nxt.prdata = hit ? rd : '0;
    end
    if (wr && st_r.pslverr == 1'b0) begin
      if (PADDR == OFS_CTRL) begin
        st_nxt.auto_mode = PWDATA[CTRL_AUTO_BIT];
        st_nxt.man_bkp = PWDATA[CTRL_MAN_BIT];
      end
      for (int i = 0; i < 4; i++) begin
        if (PADDR == OFS_PEND + 8'(4 * i)) begin
          st_nxt.pend[i] = PWDATA[LVL_W-1:0];
        end
      end
    end
    // Confirm leaves the pending copies equal to what now stands; cancel drops the edit.
    if (commit) begin
      for (int i = 0; i < 4; i++) begin
        st_nxt.pend[i] = ok[i] ? st_r.pend[i] : act[i]; // see [R12]
      end
      st_nxt.rej = !(&ok); // see [R09]
    end else if (cancel) begin
      st_nxt.pend = act; // see [R12]
    end
    // Manual mode follows the operator; automatic moves only on an expired timer.
    if (!st_r.auto_mode) begin
      st_nxt.src = st_r.man_bkp ? FO_BKUP : FO_MAIN; // see [R11]
    end else begin
      unique case (st_r.src)
        FO_MAIN: begin
          if (chg_done) begin
            st_nxt.src = FO_BKUP; // see [R02] see [R03]
          end
        end
        FO_BKUP: begin
          if (ret_done) begin
            st_nxt.src = FO_MAIN; // see [R04]
          end
        end
        // An illegal code falls back to main rather than leaving the output lost.
        default: begin
          st_nxt.src = FO_MAIN;
        end
      endcase
    end
  end

  // Everything resets to automatic mode on main with factory settings pending.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_r <= '0;
      st_r.auto_mode <= CTRL_AUTO_RST;
      st_r.man_bkp <= CTRL_MAN_RST;
      st_r.src <= FO_MAIN;
      st_r.pend <= {THR_RST, THR_RST, DLY_RST, DLY_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops.
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign SRC_BACKUP = st_r.src[1];

  // Source selection moves only as the timers and the mode allow.
  no_fail_above_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R01]
    (st_r.auto_mode && st_r.src == FO_MAIN && $signed(MAIN_LEVEL) >= $signed(act[P_CTHR]))
    |=> st_r.src == FO_MAIN)
    else $error("switched to backup with main above threshold");
  chg_after_dly_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R02]
    ($past(st_r.auto_mode) && $rose(st_r.src == FO_BKUP)) |-> $past(chg_done))
    else $error("backup selected before changeover delay");
  short_dip_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R03]
    (st_r.auto_mode && st_r.src == FO_MAIN && !chg_run) ##1 st_r.auto_mode
    |-> st_r.src == FO_MAIN)
    else $error("transfer without a sustained dip");
  ret_after_dly_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R04]
    ($past(st_r.auto_mode) && $fell(st_r.src == FO_BKUP)) |-> $past(ret_done))
    else $error("main restored before return delay");

  // Stored settings stay inside their legal ranges at all times.
  dly_range_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R05]
    $signed(act[P_CDLY]) >= DLY_MIN && $signed(act[P_CDLY]) <= DLY_MAX &&
    $signed(act[P_RDLY]) >= DLY_MIN && $signed(act[P_RDLY]) <= DLY_MAX)
    else $error("delay out of range");
  // Checked at the first edge after release; before the first reset edge the flops are unknown.
  reset_dflt_a: assert property (@(posedge MCLK) // see [R06]
    $fell(SRST) |-> act[P_CDLY] == DLY_RST && act[P_RDLY] == DLY_RST)
    else $error("delays not at default after reset");
  reset_thr_a: assert property (@(posedge MCLK) // see [R08]
    $fell(SRST) |-> act[P_CTHR] == THR_RST && act[P_RTHR] == THR_RST)
    else $error("thresholds not at default after reset");
  thr_range_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R07]
    $signed(act[P_CTHR]) >= THR_MIN && $signed(act[P_CTHR]) <= THR_MAX)
    else $error("changeover threshold out of range");
  // A later raise of the changeover threshold may leave the stored return level below it.
  ret_order_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R09]
    $changed(act[P_RTHR]) |-> $signed(act[P_RTHR]) >= $signed(act[P_CTHR]))
    else $error("return threshold stored below changeover threshold");

  // Mode decides whether the timers may act at all.
  manual_idle_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R10]
    !st_r.auto_mode |-> !chg_run && !ret_run)
    else $error("timer running in manual mode");
  manual_src_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R11]
    !st_r.auto_mode |=> SRC_BACKUP == $past(st_r.man_bkp))
    else $error("manual selection not followed");
  cancel_keep_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R12]
    cancel |=> $stable(act) && st_r.pend == act)
    else $error("cancel did not restore stored values");
  auto_only_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R10]
    (chg_done || ret_done) |-> st_r.auto_mode)
    else $error("timer expired outside automatic mode");

  // A confirm leaves the pending copies equal to the stored values and reports refusals.
  commit_reload_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R12]
    commit |=> st_r.pend == act)
    else $error("pending copies differ from stored values after confirm");
  rej_flag_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R09]
    (commit && !ok[P_RTHR]) |=> st_r.rej)
    else $error("refused return threshold not reported");
  rej_clear_a: assert property (@(posedge MCLK) disable iff (SRST) // see [R09]
    (commit && (&ok)) |=> !st_r.rej)
    else $error("refusal flag left set after a clean confirm");

  // The bus answers in the cycle after setup and at no other time.
  ready_after_setup_a: assert property (@(posedge MCLK) disable iff (SRST)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("no ready in the access cycle");
  ready_only_access_a: assert property (@(posedge MCLK) disable iff (SRST)
    !(PSEL && !PENABLE) |=> !PREADY)
    else $error("ready outside an access cycle");
  err_with_ready_a: assert property (@(posedge MCLK) disable iff (SRST)
    PSLVERR |-> PREADY)
    else $error("error flag without ready");
endmodule : fo_failover
`default_nettype wire

// *** fo_src_mdl.sv ***
// Purpose: Model of the main audio input peak meter feeding the failover block.
// Assumes: The bench picks the level; the meter presents it one clock later.
// Notes: The level is registered so it changes only on the MCLK edge the block samples.
`timescale 1ns/1ns
`default_nettype none
module fo_src_mdl import fo_pkg::*; (
  input wire logic mclk,
  input wire logic signed [LVL_W-1:0] lvl_req,
  output logic signed [LVL_W-1:0] main_level
);
  // One new peak reading per clock, as a meter read each sample period would give.
  always_ff @(posedge mclk) begin
    main_level <= lvl_req;
  end
endmodule : fo_src_mdl
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the audio source failover block.
// Assumes: TICK_CYCLES is cut to 4 so a delay of N tenths lasts about 4N cycles.
// Notes: Every wait is bounded; a wait that runs out ends the run with a failure.
`timescale 1ns/1ns
`default_nettype none
module tb_top import fo_pkg::*; ;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [LVL_W-1:0] lvl_req = -13'sh0064;
  logic signed [LVL_W-1:0] main_level;
  logic src_backup;
  int num_errors = 0;
  int total_checks = 0;

  // Clock of 50 ns period.
  always #25 mclk = ~mclk;

  fo_failover #(.TICK_CYCLES(4)) dut_u (.MCLK(mclk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MAIN_LEVEL(main_level), .SRC_BACKUP(src_backup));
  fo_src_mdl src_u (.mclk(mclk), .lvl_req(lvl_req), .main_level(main_level));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Sign extension of a 13-bit setting, as the block returns it on reads.
  function automatic logic [31:0] sx(input logic signed [LVL_W-1:0] v);
    return {{(32 - LVL_W){v[LVL_W-1]}}, v};
  endfunction : sx

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    chk_bit("pready", 1'b0, pready);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("[ERR] pready expected 1 seen %b", pready);
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk_bit("pslverr", e, err);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] got;
    logic err;
    apb(1'b0, a, 32'h00000000, got, err);
    chk_word("prdata", exp, got);
    chk_bit("pslverr", e, err);
  endtask : rd

  task automatic lvl(input logic signed [LVL_W-1:0] v);
    @(posedge mclk);
    lvl_req <= v;
  endtask : lvl

  // Waits a bounded number of cycles for the selected source to become exp.
  task automatic wait_src(input logic exp, input int lim);
    int n;
    n = 0;
    while (src_backup !== exp && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk_bit("src_backup", exp, src_backup);
    if (src_backup !== exp) begin
      final_report();
    end
  endtask : wait_src

  task automatic t_reset();
    rd(OFS_ACT, sx(DLY_RST), 1'b0);
    rd(OFS_ACT + 8'h04, sx(DLY_RST), 1'b0);
    rd(OFS_ACT + 8'h08, sx(THR_RST), 1'b0);
    rd(OFS_ACT + 8'h0C, sx(THR_RST), 1'b0);
    rd(OFS_PEND, sx(DLY_RST), 1'b0);
    rd(OFS_PEND + 8'h0C, sx(THR_RST), 1'b0);
    rd(OFS_CTRL, 32'h00000001, 1'b0);
    rd(OFS_STAT, 32'h00000000, 1'b0);
    rd(8'h40, 32'h00000000, 1'b1);
    wr(OFS_ACT, 32'h00000001, 1'b1);
    chk_bit("src_backup", 1'b0, src_backup);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    wr(OFS_PEND, 32'h00000002, 1'b0);
    wr(OFS_PEND + 8'h04, 32'h00000003, 1'b0);
    wr(OFS_PEND + 8'h08, sx(-13'sh012C), 1'b0);
    wr(OFS_PEND + 8'h0C, sx(-13'sh00C8), 1'b0);
    rd(OFS_ACT, sx(DLY_RST), 1'b0);
    wr(OFS_CMT, 32'h00000001, 1'b0);
    rd(OFS_ACT, 32'h00000002, 1'b0);
    rd(OFS_ACT + 8'h04, 32'h00000003, 1'b0);
    rd(OFS_ACT + 8'h08, sx(-13'sh012C), 1'b0);
    rd(OFS_ACT + 8'h0C, sx(-13'sh00C8), 1'b0);
    // An edit dropped by cancel leaves both copies at the stored value.
    wr(OFS_PEND, 32'h00000005, 1'b0);
    wr(OFS_CMT, 32'h00000002, 1'b0);
    rd(OFS_ACT, 32'h00000002, 1'b0);
    rd(OFS_PEND, 32'h00000002, 1'b0);
    // Zero delay, zero threshold and a return level under changeover are all refused.
    wr(OFS_PEND, 32'h00000000, 1'b0);
    wr(OFS_PEND + 8'h08, 32'h00000000, 1'b0);
    wr(OFS_PEND + 8'h0C, sx(-13'sh0190), 1'b0);
    wr(OFS_CMT, 32'h00000001, 1'b0);
    rd(OFS_ACT, 32'h00000002, 1'b0);
    rd(OFS_ACT + 8'h08, sx(-13'sh012C), 1'b0);
    rd(OFS_ACT + 8'h0C, sx(-13'sh00C8), 1'b0);
    rd(OFS_STAT, 32'h00000008, 1'b0);
    wr(OFS_CMT, 32'h00000001, 1'b0);
    rd(OFS_STAT, 32'h00000000, 1'b0);
    $display("test config done");
  endtask : t_config

  task automatic t_dip();
    lvl(-13'sh012C);
    repeat (20) @(posedge mclk);
    chk_bit("src_backup", 1'b0, src_backup);
    lvl(-13'sh01F4);
    repeat (4) @(posedge mclk);
    lvl(-13'sh0064);
    repeat (2) @(posedge mclk);
    lvl(-13'sh01F4);
    repeat (4) @(posedge mclk);
    lvl(-13'sh0064);
    repeat (20) @(posedge mclk);
    chk_bit("src_backup", 1'b0, src_backup);
    $display("test dip done");
  endtask : t_dip

  task automatic t_failover();
    lvl(-13'sh01F4);
    // The status read takes three edges, so the first source check still lands six edges in.
    rd(OFS_STAT, 32'h00000002, 1'b0);
    repeat (3) @(posedge mclk);
    chk_bit("src_backup", 1'b0, src_backup);
    wait_src(1'b1, 8);
    rd(OFS_STAT, 32'h00000001, 1'b0);
    lvl(-13'sh00C8);
    repeat (30) @(posedge mclk);
    chk_bit("src_backup", 1'b1, src_backup);
    lvl(-13'sh0064);
    rd(OFS_STAT, 32'h00000005, 1'b0);
    repeat (7) @(posedge mclk);
    chk_bit("src_backup", 1'b1, src_backup);
    wait_src(1'b0, 10);
    $display("test failover done");
  endtask : t_failover

  task automatic t_manual();
    wr(OFS_CTRL, 32'h00000002, 1'b0);
    wait_src(1'b1, 4);
    repeat (30) @(posedge mclk);
    chk_bit("src_backup", 1'b1, src_backup);
    wr(OFS_CTRL, 32'h00000000, 1'b0);
    wait_src(1'b0, 4);
    lvl(-13'sh01F4);
    repeat (30) @(posedge mclk);
    chk_bit("src_backup", 1'b0, src_backup);
    $display("test manual done");
  endtask : t_manual

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_dip();
    t_failover();
    t_manual();
    // A second reset in mid-run must bring back every factory setting.
    srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
